//--- hw/smgc_top.v
// misc global control registers over apb, with led, clock and edge outputs
// assumes synchronous inputs; strap level valid at reset release
`timescale 1ns/1ps
`include "smgc_map.vh"
// Functional notes
// - bit 6 selects the uplink rmii sampling edge, 0 after reset.
// - bits 5:4 pick one led meaning shared by all five ports, leds lit when driven low.
// - bit 1 gates the reference clock pin, its reset value from the strap.
// - bit 0 selects the serial management read edge, 0 after reset.
module smgc_top (
  // clock and reset
  input wire CLK_SYS_I,
  input wire RESETN_I,
  // apb slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output wire PREADY_O,
  output wire PSLVERR_O,
  output reg [31:0] PRDATA_O,
  // strap and clock source
  input wire REFCLK_STRAP_I,
  input wire REFCLK_SRC_I,
  // port status, one bit per port
  input wire [4:0] PORT_LINK_I,
  input wire [4:0] PORT_ACT_I,
  input wire [4:0] PORT_SPEED100_I,
  input wire [4:0] PORT_FULL_DPX_I,
  // controls
  output wire UPLINK_RMII_ALT_EDGE_O,
  output wire SMI_READ_ALT_EDGE_O,
  output wire REF_CLOCK_OUT_PIN_O,
  output wire [4:0] PORT_LED_SECONDARY_N_O,
  output wire [4:0] PORT_LED_PRIMARY_N_O
);
  // register state
  reg [7:0] misc_q;
  reg [7:0] misc_d;
  reg [5:0] tag_q;
  reg [5:0] tag_d;
  reg strap_done_q;
  reg [31:0] rdata_d;
  // apb decode
  wire access;
  wire setup;
  wire [9:0] idx;
  wire aligned;
  reg hit_a;
  reg hit_b;
  reg hit_m;
  reg hit_t;
  wire mapped;
  wire wr_en;
  wire rd_setup;
  wire [7:0] wbyte;
  // write mask and read views
  wire [7:0] tag_mask;
  wire [7:0] tag_rd;
  wire [1:0] led_mode;
  wire refclk_en;
  assign access = PSEL_I & PENABLE_I;
  assign setup = PSEL_I & ~PENABLE_I;
  assign idx = PADDR_I[11:2];
  assign aligned = (PADDR_I[1:0] == 2'h0);
  assign mapped = hit_a | hit_b | hit_m | hit_t;
  assign wr_en = access & PWRITE_I & PREADY_O;
  assign rd_setup = setup & ~PWRITE_I;
  assign wbyte = PWDATA_I[7:0];
  assign tag_mask = `SMGC_TAG_WR_MASK;
  assign tag_rd = {`SMGC_TAG_RSVD, tag_q};
  assign led_mode = misc_q[`SMGC_BIT_LED_HI:`SMGC_BIT_LED_LO];
  assign refclk_en = misc_q[`SMGC_BIT_REFCLK_EN];
  // zero wait states; unmapped or unaligned access flagged
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access & ~mapped;
  // word index decode, aligned addresses only
  always @*
  begin
    hit_a = 1'b0;
    hit_b = 1'b0;
    hit_m = 1'b0;
    hit_t = 1'b0;
    if (aligned)
    begin
      case (idx)
        {2'h0, `SMGC_IDX_FACTORY_TEST_A}:
          hit_a = 1'b1;
        {2'h0, `SMGC_IDX_FACTORY_TEST_B}:
          hit_b = 1'b1;
        {2'h0, `SMGC_IDX_MISC_CLK_LED}:
          hit_m = 1'b1;
        {2'h0, `SMGC_IDX_TAG_FLOW}:
          hit_t = 1'b1;
        default:
          hit_a = 1'b0;
      endcase
    end
  end
  // misc next value: strap load first, then software writes
  always @*
  begin
    misc_d = misc_q;
    if (!strap_done_q)
      misc_d[`SMGC_BIT_REFCLK_EN] = REFCLK_STRAP_I;
    else if (wr_en & hit_m)
    begin
      misc_d[`SMGC_BIT_RMII_EDGE] = wbyte[`SMGC_BIT_RMII_EDGE];
      misc_d[`SMGC_BIT_LED_HI] = wbyte[`SMGC_BIT_LED_HI];
      misc_d[`SMGC_BIT_LED_LO] = wbyte[`SMGC_BIT_LED_LO];
      misc_d[`SMGC_BIT_REFCLK_EN] = wbyte[`SMGC_BIT_REFCLK_EN];
      misc_d[`SMGC_BIT_SMI_EDGE] = wbyte[`SMGC_BIT_SMI_EDGE];
    end
  end
  // tag byte: reserved bits fixed, bits 5:2 keep reset value, only bits 1:0 writable
  always @*
  begin
    tag_d = tag_q;
    if (wr_en & hit_t)
      tag_d = (tag_q & ~tag_mask[5:0]) | (wbyte[5:0] & tag_mask[5:0]);
  end
  // control state; reserved bits never written
  always @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      misc_q <= 8'h00;
      tag_q <= `SMGC_TAG_RST_LOW;
      strap_done_q <= 1'b0;
    end
    else
    begin
      misc_q <= misc_d;
      tag_q <= tag_d;
      strap_done_q <= 1'b1;
    end
  end
  // read data chosen in the setup cycle, held otherwise
  always @*
  begin
    rdata_d = PRDATA_O;
    if (rd_setup)
    begin
      if (hit_a)
        rdata_d = {24'h000000, `SMGC_RST_FACTORY_TEST_A};
      else if (hit_b)
        rdata_d = {24'h000000, `SMGC_RST_FACTORY_TEST_B};
      else if (hit_m)
        rdata_d = {24'h000000, misc_q};
      else if (hit_t)
        rdata_d = {24'h000000, tag_rd};
      else
        rdata_d = 32'h00000000;
    end
  end
  always @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      PRDATA_O <= 32'h00000000;
    else
      PRDATA_O <= rdata_d;
  end
  // control outputs
  assign UPLINK_RMII_ALT_EDGE_O = misc_q[`SMGC_BIT_RMII_EDGE];
  assign SMI_READ_ALT_EDGE_O = misc_q[`SMGC_BIT_SMI_EDGE];
  assign REF_CLOCK_OUT_PIN_O = REFCLK_SRC_I & refclk_en;
  // port 1 leds
  smgc_led_map u_led_0 (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .mode_i(led_mode),
    .link_i(PORT_LINK_I[0]),
    .act_i(PORT_ACT_I[0]),
    .speed100_i(PORT_SPEED100_I[0]),
    .full_dpx_i(PORT_FULL_DPX_I[0]),
    .led_sec_n_o(PORT_LED_SECONDARY_N_O[0]),
    .led_pri_n_o(PORT_LED_PRIMARY_N_O[0])
  );
  // port 2 leds
  smgc_led_map u_led_1 (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .mode_i(led_mode),
    .link_i(PORT_LINK_I[1]),
    .act_i(PORT_ACT_I[1]),
    .speed100_i(PORT_SPEED100_I[1]),
    .full_dpx_i(PORT_FULL_DPX_I[1]),
    .led_sec_n_o(PORT_LED_SECONDARY_N_O[1]),
    .led_pri_n_o(PORT_LED_PRIMARY_N_O[1])
  );
  // port 3 leds
  smgc_led_map u_led_2 (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .mode_i(led_mode),
    .link_i(PORT_LINK_I[2]),
    .act_i(PORT_ACT_I[2]),
    .speed100_i(PORT_SPEED100_I[2]),
    .full_dpx_i(PORT_FULL_DPX_I[2]),
    .led_sec_n_o(PORT_LED_SECONDARY_N_O[2]),
    .led_pri_n_o(PORT_LED_PRIMARY_N_O[2])
  );
  // port 4 leds
  smgc_led_map u_led_3 (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .mode_i(led_mode),
    .link_i(PORT_LINK_I[3]),
    .act_i(PORT_ACT_I[3]),
    .speed100_i(PORT_SPEED100_I[3]),
    .full_dpx_i(PORT_FULL_DPX_I[3]),
    .led_sec_n_o(PORT_LED_SECONDARY_N_O[3]),
    .led_pri_n_o(PORT_LED_PRIMARY_N_O[3])
  );
  // uplink port leds
  smgc_led_map u_led_4 (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .mode_i(led_mode),
    .link_i(PORT_LINK_I[4]),
    .act_i(PORT_ACT_I[4]),
    .speed100_i(PORT_SPEED100_I[4]),
    .full_dpx_i(PORT_FULL_DPX_I[4]),
    .led_sec_n_o(PORT_LED_SECONDARY_N_O[4]),
    .led_pri_n_o(PORT_LED_PRIMARY_N_O[4])
  );
endmodule // smgc_top

//--- inc/smgc_map.vh
// register offsets, fields and reset values of the misc global control bank
// assumes byte addresses on a 32-bit apb, one register per word
`ifndef SMGC_MAP_VH
`define SMGC_MAP_VH
// printed offsets are register indices; byte address is four times
`define SMGC_IDX_FACTORY_TEST_A 8'h09
`define SMGC_IDX_FACTORY_TEST_B 8'h0A
`define SMGC_IDX_MISC_CLK_LED 8'h0B
`define SMGC_IDX_TAG_FLOW 8'h0C
`define SMGC_RST_FACTORY_TEST_A 8'h40
`define SMGC_RST_FACTORY_TEST_B 8'h00
// misc clock led control fields
`define SMGC_BIT_RMII_EDGE 6
`define SMGC_BIT_LED_HI 5
`define SMGC_BIT_LED_LO 4
`define SMGC_BIT_REFCLK_EN 1
`define SMGC_BIT_SMI_EDGE 0
`define SMGC_MISC_WR_MASK 8'h73
// tag and flow control: top reserved bits read 01, bits 5:2 hold reset value, only bits 1:0 writable
`define SMGC_TAG_RSVD 2'h1
`define SMGC_TAG_RST_LOW 6'h04
`define SMGC_TAG_WR_MASK 8'h03
// led modes
`define SMGC_LED_SPD_LNKACT 2'h0
`define SMGC_LED_ACT_LNK 2'h1
`define SMGC_LED_DPX_LNKACT 2'h2
`define SMGC_LED_DPX_LNK 2'h3
`endif

//--- hw/smgc_led_map.v
// one port's led mapping from mode and port status
// assumes status inputs already synchronous; outputs low = lit
`timescale 1ns/1ps
`include "smgc_map.vh"
module smgc_led_map (
  input wire clk_i,
  input wire rst_n_i,
  input wire [1:0] mode_i,
  input wire link_i,
  input wire act_i,
  input wire speed100_i,
  input wire full_dpx_i,
  output reg led_sec_n_o,
  output reg led_pri_n_o
);
  reg sec_on;
  reg pri_on;
  always @*
  begin
    case (mode_i)
      `SMGC_LED_SPD_LNKACT:
      begin
        sec_on = speed100_i;
        pri_on = link_i & ~act_i;
      end
      `SMGC_LED_ACT_LNK:
      begin
        sec_on = act_i;
        pri_on = link_i;
      end
      `SMGC_LED_DPX_LNKACT:
      begin
        sec_on = full_dpx_i;
        pri_on = link_i & ~act_i;
      end
      default:
      begin
        sec_on = full_dpx_i;
        pri_on = link_i;
      end
    endcase
  end
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      led_sec_n_o <= 1'b1;
      led_pri_n_o <= 1'b1;
    end
    else
    begin
      led_sec_n_o <= ~sec_on;
      led_pri_n_o <= ~pri_on;
    end
  end
endmodule // smgc_led_map

//--- dv/smgc_top_properties.sv
// control output checks
// assumes smgc_top apb slave
`timescale 1ns/1ps
module smgc_chk (
  input wire CLK_SYS_I, RESETN_I, PSEL_I, PENABLE_I, PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire REFCLK_SRC_I, REF_CLOCK_OUT_PIN_O,
  input wire UPLINK_RMII_ALT_EDGE_O, SMI_READ_ALT_EDGE_O
);
  wire w = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 12'h02C;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  AST_RMII: assert property (w |=> UPLINK_RMII_ALT_EDGE_O ==
    $past(PWDATA_I[6])) else $error("rmii edge");
  AST_SMI: assert property (w |=> SMI_READ_ALT_EDGE_O ==
    $past(PWDATA_I[0])) else $error("smi edge");
  AST_GATE: assert property (REF_CLOCK_OUT_PIN_O |-> REFCLK_SRC_I)
    else $error("ref gate");
  AST_OFF: assert property (w && !PWDATA_I[1] |=>
    !REF_CLOCK_OUT_PIN_O [*2]) else $error("ref off");
  cover property (w && PWDATA_I[6]);
  cover property (w && PWDATA_I[0]);
  cover property (REF_CLOCK_OUT_PIN_O);
endmodule // smgc_chk
bind smgc_top smgc_chk u_chk (
  .CLK_SYS_I(CLK_SYS_I),
  .RESETN_I(RESETN_I),
  .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I),
  .REFCLK_SRC_I(REFCLK_SRC_I),
  .REF_CLOCK_OUT_PIN_O(REF_CLOCK_OUT_PIN_O),
  .UPLINK_RMII_ALT_EDGE_O(UPLINK_RMII_ALT_EDGE_O),
  .SMI_READ_ALT_EDGE_O(SMI_READ_ALT_EDGE_O)
);

//--- dv/smgc_host.sv
// apb master for host software
// assumes zero or more wait states
`timescale 1ns/1ps
module smgc_host (
  // apb master side
  input wire CLK_SYS_I, PREADY_O, PSLVERR_O,
  input wire [31:0] PRDATA_O,
  output reg PSEL_I = 1'h0, PENABLE_I = 1'h0, PWRITE_I = 1'h0,
  output reg [11:0] PADDR_I = 12'h000,
  output reg [31:0] PWDATA_I = 32'h0
);
  reg [31:0] r;
  reg e;
  task xf(input w, input [11:0] a, input [31:0] d);
    @(posedge CLK_SYS_I);
    PSEL_I <= 1'h1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_SYS_I);
    PENABLE_I <= 1'h1;
    @(posedge CLK_SYS_I);
    while (!PREADY_O)
      @(posedge CLK_SYS_I);
    r = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I <= 1'h0;
    PENABLE_I <= 1'h0;
  endtask
endmodule // smgc_host

//--- dv/smgc_top_tb.sv
// self-checking apb bench
// assumes smgc_host as bus master
`timescale 1ns/1ps
module smgc_top_tb;
  reg CLK_SYS_I = 0, RESETN_I = 0, REFCLK_SRC_I = 0, REFCLK_STRAP_I = 1;
  reg [4:0] PORT_LINK_I = 0, PORT_ACT_I = 0, PORT_SPEED100_I = 0;
  reg [4:0] PORT_FULL_DPX_I = 0;
  wire PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O;
  wire UPLINK_RMII_ALT_EDGE_O, SMI_READ_ALT_EDGE_O, REF_CLOCK_OUT_PIN_O;
  wire [11:0] PADDR_I;
  wire [31:0] PWDATA_I, PRDATA_O;
  wire [4:0] PORT_LED_SECONDARY_N_O, PORT_LED_PRIMARY_N_O;
  integer bad_count = 0, cmp_count = 0, m;
  smgc_top DUT (.*);
  smgc_host h (.*);
  initial forever #25 CLK_SYS_I = ~CLK_SYS_I;
  always @(posedge CLK_SYS_I) REFCLK_SRC_I <= ~REFCLK_SRC_I;
  initial
  begin
    repeat (3000) @(posedge CLK_SYS_I);
    bad_count++;
    give_verdict;
  end
  task chk(input [31:0] s, x);
    cmp_count++;
    if (s !== x)
    begin
      bad_count++;
      $display("[FAIL] %0t %h %h", $time, s, x);
    end
  endtask
  task give_verdict;
    $display("%0d bad of %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task t_reg;
    h.xf(0, 12'h024, 0);
    chk(h.r, 32'h40);
    h.xf(0, 12'h028, 0);
    chk(h.r, 32'h00);
    h.xf(0, 12'h030, 0);
    chk(h.r, 32'h44);
    h.xf(0, 12'h02C, 0);
    chk(h.r, 32'h02);
    h.xf(0, 12'h100, 0);
    chk(h.e, 1);
    h.xf(1, 12'h02C, 32'h73);
    h.xf(0, 12'h02C, 0);
    chk(h.r, 32'h73);
    chk({UPLINK_RMII_ALT_EDGE_O, SMI_READ_ALT_EDGE_O}, 3);
    chk(REF_CLOCK_OUT_PIN_O, REFCLK_SRC_I);
    @(posedge CLK_SYS_I);
    chk(REF_CLOCK_OUT_PIN_O, REFCLK_SRC_I);
    $display("t_reg done");
  endtask
  task t_led;
    PORT_LINK_I <= 5'h1F;
    PORT_ACT_I <= 5'h03;
    PORT_SPEED100_I <= 5'h05;
    PORT_FULL_DPX_I <= 5'h0A;
    for (m = 0; m < 4; m++)
    begin
      h.xf(1, 12'h02C, m << 4);
      repeat (2) @(posedge CLK_SYS_I);
      chk(PORT_LED_SECONDARY_N_O, 20'hAD79A >> 5 * m & 5'h1F);
      chk(PORT_LED_PRIMARY_N_O, 20'h00C03 >> 5 * m & 5'h1F);
    end
    chk({UPLINK_RMII_ALT_EDGE_O, SMI_READ_ALT_EDGE_O}, 0);
    chk(REF_CLOCK_OUT_PIN_O, 0);
    $display("t_led done");
  endtask
  task t_strap;
    REFCLK_STRAP_I <= 0;
    RESETN_I <= 0;
    repeat (3) @(posedge CLK_SYS_I);
    RESETN_I <= 1;
    repeat (2) @(posedge CLK_SYS_I);
    h.xf(0, 12'h02C, 0);
    chk(h.r, 32'h00);
    chk(REF_CLOCK_OUT_PIN_O, 0);
    $display("t_strap done");
  endtask
  initial
  begin
    repeat (12) @(posedge CLK_SYS_I);
    RESETN_I <= 1;
    repeat (2) @(posedge CLK_SYS_I);
    t_reg;
    t_led;
    t_strap;
    give_verdict;
  end
endmodule // smgc_top_tb
